// file: verilog/board_regs_params.svh
// constants of the board system register bank
`ifndef BOARD_REGS_PARAMS_SVH
`define BOARD_REGS_PARAMS_SVH

// ----------------------------------------------------------------------
// register addresses in i/o space
// ----------------------------------------------------------------------
`define OFS_WDT_CFG        16'h8203
`define OFS_OPTION         16'h8204
`define OFS_SETUP          16'h8205
`define OFS_REVISION       16'h8206
`define OFS_BOOT_MODE      16'h820A
`define OFS_SENSOR_PORT    16'h820B

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define WDT_LOCK_BIT       7
`define WDT_TSEL_MSB       3
`define WDT_TSEL_LSB       0
`define SETUP_READY_BIT    7
`define SETUP_RUN_BIT      6
`define SETUP_AUX_BIT      5
`define SETUP_USB_MSB      2
`define SETUP_USB_LSB      0
`define SENSOR_CLK_BIT     7
`define SENSOR_DATA_BIT    6

// ----------------------------------------------------------------------
// reset values and fixed read values
// ----------------------------------------------------------------------
`define WDT_CFG_RESET      8'h80
`define SETUP_RESET        8'h07
`define SENSOR_RESET       8'hFF
`define SENSOR_LOW_ONES    4'hF
`define UNMAPPED_READ      8'hFF
`define BOOT_PAD           6'h00
`define SETUP_PAD          2'h0
`define WDT_PAD            3'h0

// ----------------------------------------------------------------------
// command codes written to the option register
// ----------------------------------------------------------------------
`define CMD_HW_RESET       8'hA5
`define CMD_POWER_CYCLE    8'h5A

// ----------------------------------------------------------------------
// watchdog timing
// ----------------------------------------------------------------------
`define CLK_MHZ            200
`define WDT_TICK_MS        100
`define WDT_TICK_CYCLES    (`WDT_TICK_MS * 1000 * `CLK_MHZ)
`define WDT_TICK_W         25
`define WDT_PER_W          12
`define WDT_SHORT_MS       100
`define WDT_BASE_S         1
`define WDT_S_CODE1        4
`define WDT_S_CODE2        8
`define WDT_S_CODE3        16
`define WDT_S_CODE4        32
`define WDT_S_CODE5        64
`define WDT_S_CODE6        128
`define WDT_S_CODE7        256
`define TICKS_MS(ms)       ((ms) / `WDT_TICK_MS)
`define TICKS_S(s)         (((s) * 1000) / `WDT_TICK_MS)

`endif

// file: verilog/board_regs_pkg.sv
// types shared by the board system register bank
package board_regs_pkg;

    // ------------------------------------------------------------------
    // i/o space access from the host processor
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
    } io_req_s;

    // ------------------------------------------------------------------
    // two-way open-collector pin, enable high while pulling low
    // ------------------------------------------------------------------
    typedef struct packed {
        logic o;
        logic oe;
    } oc_pin_s;

endpackage

// file: verilog/watchdog_timer.sv
// watchdog prescaler and timeout counter
`timescale 1ns/1ps
`default_nettype none
`include "board_regs_params.svh"

module watchdog_timer #(
    parameter int TICK_CYCLES = `WDT_TICK_CYCLES,
    parameter int TICK_W      = `WDT_TICK_W,
    parameter int PER_W       = `WDT_PER_W
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    input  wire logic              ce,
    // control
    input  wire logic              run,
    input  wire logic              restart,
    input  wire logic [PER_W-1:0]  period_ticks,
    // event
    output logic                   expire
);

    logic [TICK_W-1:0] pre_q;
    logic [PER_W-1:0]  cnt_q;
    logic              done_q;
    logic              tick;
    logic              hit;

    assign tick = (pre_q == TICK_W'(TICK_CYCLES - 1));
    assign hit  = run && !done_q && tick && (cnt_q + 1'b1 >= period_ticks);

    // ------------------------------------------------------------------
    // prescaler, realigned on every restart so a period never runs short
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pre_q <= '0;
        end else if (ce) begin
            if (!run || restart || tick) begin
                pre_q <= '0;
            end else begin
                pre_q <= pre_q + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // period counter; expiry fires once, then waits for a kick
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_q  <= '0;
            done_q <= 1'b0;
        end else if (ce) begin
            if (!run || restart) begin
                cnt_q  <= '0;
                done_q <= 1'b0;
            end else if (hit) begin
                cnt_q  <= '0;
                done_q <= 1'b1;
            end else if (tick && !done_q) begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            expire <= 1'b0;
        end else if (ce) begin
            expire <= hit;
        end
    end

endmodule

`default_nettype wire

// file: verilog/board_system_register_bank.sv
// board system register bank in host i/o space
//
// Function
// - timeout code 0: 1 s on even switch, 100 ms odd; 1..7: 4..256 s
// - nonzero timeout codes ignore the configuration switch
// - lock bit D7 stops a running watchdog from being disabled; reads back
// - watchdog config D6..D4 read zero; software writes zero there
// - writing A5h commands a board hardware reset and clears timeout flag
// - writing 5Ah commands a power cycle and clears timeout flag
// - revision register reads a fixed design revision code; write zeros
// - setup D7 drives the front ready LED and reads back
// - setup D6 enables the watchdog and reads back its state
// - setup D5 drives the aux LED; D4 and D3 read zero
// - setup D2..D0 each power one USB port pair, readable
// - boot mode register reads two boot inputs, upper bits zero
// - sensor port D7/D6 are open-collector latches; reads return pins
// - sensor port D5/D4 read the clock and data pin levels
// - sensor port low nibble reads ones; software writes ones
// - any change of the kick bit restarts the watchdog timeout
// - action select picks hardware reset or nmi on expiry
// - active-low timeout flag stays low until a commanded reset
// - watchdog is disabled after power-on
`timescale 1ns/1ps
`default_nettype none
`include "board_regs_params.svh"

module board_system_register_bank #(
    parameter int         TICK_CYCLES   = `WDT_TICK_CYCLES,
    parameter logic [7:0] OPTION_CODE   = 8'h3C, // arbitrary value
    parameter logic [7:0] REVISION_CODE = 8'h01  // arbitrary value
) (
    // clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    resetn,
    input  wire logic                    ce,
    // host i/o space access
    input  wire board_regs_pkg::io_req_s io_req,
    output logic [7:0]                   io_rdata,
    // watchdog bits held elsewhere on the board
    input  wire logic                    watchdog_kick,
    input  wire logic                    timeout_action_select,
    input  wire logic [3:0]              config_switch,
    output logic                         timeout_occurred_n,
    // reset, power and interrupt requests
    output logic                         hw_reset_pulse,
    output logic                         power_cycle_pulse,
    output logic                         wdt_reset_pulse,
    output logic                         wdt_nmi_pulse,
    // front panel and usb power
    output logic                         ready_led,
    output logic                         aux_led,
    output logic                         usb_pair_power_a,
    output logic                         usb_pair_power_b,
    output logic                         usb_pair_power_c,
    // boot mode straps
    input  wire logic [1:0]              boot_select_inputs,
    // temperature sensor two-wire port
    input  wire logic                    sensor_clk_in,
    input  wire logic                    sensor_data_in,
    output board_regs_pkg::oc_pin_s      sensor_clk_pin,
    output board_regs_pkg::oc_pin_s      sensor_data_pin
);

    import board_regs_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic                  lock_q;
    logic [3:0]            tsel_q;
    logic                  ready_q;
    logic                  run_q;
    logic                  run_d;
    logic                  aux_q;
    logic [2:0]            usb_q;
    logic                  clk_latch_q;
    logic                  data_latch_q;
    logic                  occurred_q;
    logic                  kick_prev_q;
    logic                  hw_reset_q;
    logic                  power_cycle_q;
    logic                  wdt_reset_q;
    logic                  wdt_nmi_q;
    logic [7:0]            rdata_q;

    logic                  wr_wdt;
    logic                  wr_option;
    logic                  wr_setup;
    logic                  wr_sensor;
    logic                  cmd_hw;
    logic                  cmd_pwr;
    logic                  restart;
    logic                  expire;
    logic [`WDT_PER_W-1:0] period_ticks;

    // ------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------
    assign wr_wdt    = io_req.wr && (io_req.addr == `OFS_WDT_CFG);
    assign wr_option = io_req.wr && (io_req.addr == `OFS_OPTION);
    assign wr_setup  = io_req.wr && (io_req.addr == `OFS_SETUP);
    assign wr_sensor = io_req.wr && (io_req.addr == `OFS_SENSOR_PORT);
    assign cmd_hw    = wr_option && (io_req.wdata == `CMD_HW_RESET);
    assign cmd_pwr   = wr_option && (io_req.wdata == `CMD_POWER_CYCLE);

    // ------------------------------------------------------------------
    // watchdog configuration register
    // ------------------------------------------------------------------
    // reserved bits are not stored, so they always read back as zero
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lock_q <= 1'(`WDT_CFG_RESET >> `WDT_LOCK_BIT);
            tsel_q <= 4'(`WDT_CFG_RESET);
        end else if (ce && wr_wdt) begin
            lock_q <= io_req.wdata[`WDT_LOCK_BIT];
            tsel_q <= io_req.wdata[`WDT_TSEL_MSB:`WDT_TSEL_LSB];
        end
    end

    // ------------------------------------------------------------------
    // period selection, in prescaler ticks
    // ------------------------------------------------------------------
    // codes above seven are undefined; they take the longest period
    always_comb begin
        case (tsel_q)
            4'h0: begin
                if (config_switch[0]) begin
                    period_ticks = `WDT_PER_W'(`TICKS_MS(`WDT_SHORT_MS));
                end else begin
                    period_ticks = `WDT_PER_W'(`TICKS_S(`WDT_BASE_S));
                end
            end
            // switch is not looked at below this point
            4'h1: period_ticks = `WDT_PER_W'(`TICKS_S(`WDT_S_CODE1));
            4'h2: period_ticks = `WDT_PER_W'(`TICKS_S(`WDT_S_CODE2));
            4'h3: period_ticks = `WDT_PER_W'(`TICKS_S(`WDT_S_CODE3));
            4'h4: period_ticks = `WDT_PER_W'(`TICKS_S(`WDT_S_CODE4));
            4'h5: period_ticks = `WDT_PER_W'(`TICKS_S(`WDT_S_CODE5));
            4'h6: period_ticks = `WDT_PER_W'(`TICKS_S(`WDT_S_CODE6));
            default: period_ticks = `WDT_PER_W'(`TICKS_S(`WDT_S_CODE7));
        endcase
    end

    // ------------------------------------------------------------------
    // setup register
    // ------------------------------------------------------------------
    always_comb begin
        run_d = run_q;
        if (wr_setup) begin
            if (lock_q && run_q) begin
                run_d = 1'b1;
            end else begin
                run_d = io_req.wdata[`SETUP_RUN_BIT];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ready_q <= 1'(`SETUP_RESET >> `SETUP_READY_BIT);
            run_q   <= 1'(`SETUP_RESET >> `SETUP_RUN_BIT);
            aux_q   <= 1'(`SETUP_RESET >> `SETUP_AUX_BIT);
            usb_q   <= 3'(`SETUP_RESET);
        end else if (ce) begin
            run_q <= run_d;
            if (wr_setup) begin
                ready_q <= io_req.wdata[`SETUP_READY_BIT];
                aux_q   <= io_req.wdata[`SETUP_AUX_BIT];
                usb_q   <= io_req.wdata[`SETUP_USB_MSB:`SETUP_USB_LSB];
            end
        end
    end

    assign ready_led        = ready_q;
    assign aux_led          = aux_q;
    assign usb_pair_power_a = usb_q[0];
    assign usb_pair_power_b = usb_q[1];
    assign usb_pair_power_c = usb_q[2];

    // ------------------------------------------------------------------
    // watchdog kick detection and timer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            kick_prev_q <= 1'b0;
        end else if (ce) begin
            kick_prev_q <= watchdog_kick;
        end
    end

    // either edge of the kick counts, as does a fresh enable
    assign restart = (watchdog_kick != kick_prev_q) || (run_d && !run_q);

    watchdog_timer #(
        .TICK_CYCLES (TICK_CYCLES),
        .TICK_W      (`WDT_TICK_W),
        .PER_W       (`WDT_PER_W)
    ) u_timer (
        .clk_sys      (clk_sys),
        .resetn       (resetn),
        .ce           (ce),
        .run          (run_q),
        .restart      (restart),
        .period_ticks (period_ticks),
        .expire       (expire)
    );

    // ------------------------------------------------------------------
    // expiry action and sticky timeout flag
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wdt_reset_q <= 1'b0;
            wdt_nmi_q   <= 1'b0;
        end else if (ce) begin
            wdt_reset_q <= expire && !timeout_action_select;
            wdt_nmi_q   <= expire && timeout_action_select;
        end
    end

    // the flag must survive the board reset it requests, so an expiry
    // that meets a clearing command in the same cycle still sets it
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            occurred_q <= 1'b0;
        end else if (ce) begin
            if (expire) begin
                occurred_q <= 1'b1;
            end else if (cmd_hw || cmd_pwr) begin
                occurred_q <= 1'b0;
            end
        end
    end

    assign timeout_occurred_n = !occurred_q;

    // ------------------------------------------------------------------
    // reset and power commands
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hw_reset_q    <= 1'b0;
            power_cycle_q <= 1'b0;
        end else if (ce) begin
            hw_reset_q    <= cmd_hw;
            power_cycle_q <= cmd_pwr;
        end
    end

    assign hw_reset_pulse    = hw_reset_q;
    assign power_cycle_pulse = power_cycle_q;
    assign wdt_reset_pulse   = wdt_reset_q;
    assign wdt_nmi_pulse     = wdt_nmi_q;

    // ------------------------------------------------------------------
    // sensor port latches, open collector
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            clk_latch_q  <= 1'(`SENSOR_RESET >> `SENSOR_CLK_BIT);
            data_latch_q <= 1'(`SENSOR_RESET >> `SENSOR_DATA_BIT);
        end else if (ce && wr_sensor) begin
            clk_latch_q  <= io_req.wdata[`SENSOR_CLK_BIT];
            data_latch_q <= io_req.wdata[`SENSOR_DATA_BIT];
        end
    end

    // a one only releases the line; the pull-up gives the high level
    assign sensor_clk_pin.o   = 1'b0;
    assign sensor_clk_pin.oe  = !clk_latch_q;
    assign sensor_data_pin.o  = 1'b0;
    assign sensor_data_pin.oe = !data_latch_q;

    // ------------------------------------------------------------------
    // read path, registered on the read strobe
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= `UNMAPPED_READ;
        end else if (ce && io_req.rd) begin
            case (io_req.addr)
                `OFS_WDT_CFG: begin
                    rdata_q <= {lock_q, `WDT_PAD, tsel_q};
                end
                `OFS_OPTION: begin
                    rdata_q <= OPTION_CODE;
                end
                `OFS_SETUP: begin
                    rdata_q <= {ready_q, run_q, aux_q, `SETUP_PAD, usb_q};
                end
                `OFS_REVISION: begin
                    rdata_q <= REVISION_CODE;
                end
                `OFS_BOOT_MODE: begin
                    rdata_q <= {`BOOT_PAD, boot_select_inputs};
                end
                `OFS_SENSOR_PORT: begin
                    rdata_q <= {sensor_clk_in, sensor_data_in,
                                sensor_clk_in, sensor_data_in,
                                `SENSOR_LOW_ONES};
                end
                default: begin
                    rdata_q <= `UNMAPPED_READ;
                end
            endcase
        end
    end

    assign io_rdata = rdata_q;

endmodule

`default_nettype wire

// file: bench/board_regs_chk_assertions.sv
// assertion checker for the board system register bank
`timescale 1ns/1ps
`default_nettype none

module board_regs_chk #(
    parameter logic [7:0] REVISION_CODE = 8'h01
) (
    // clock and reset
    input wire logic                    clk_sys,
    input wire logic                    resetn,
    input wire logic                    ce,
    // host access
    input wire board_regs_pkg::io_req_s io_req,
    input wire logic [7:0]              io_rdata,
    // watchdog and commands
    input wire logic                    timeout_action_select,
    input wire logic                    timeout_occurred_n,
    input wire logic                    hw_reset_pulse,
    input wire logic                    power_cycle_pulse,
    input wire logic                    wdt_reset_pulse,
    input wire logic                    wdt_nmi_pulse,
    // panel, usb, straps and sensor
    input wire logic                    ready_led,
    input wire logic                    aux_led,
    input wire logic                    usb_pair_power_a,
    input wire logic                    usb_pair_power_b,
    input wire logic                    usb_pair_power_c,
    input wire logic [1:0]              boot_select_inputs,
    input wire board_regs_pkg::oc_pin_s sensor_clk_pin,
    input wire board_regs_pkg::oc_pin_s sensor_data_pin
);
    import board_regs_pkg::*;

    // ------------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------------
    logic [7:0] wd_q;
    logic [1:0] bs_q;
    logic       a5_q;
    logic       x5a_q;
    wire logic  wr_ok = ce && io_req.wr;
    wire logic  rd_ok = ce && io_req.rd;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            a5_q  <= 1'b0;
            x5a_q <= 1'b0;
        end else if (ce) begin
            a5_q  <= wr_ok && io_req.addr == 16'h8204 && io_req.wdata == 8'hA5;
            x5a_q <= wr_ok && io_req.addr == 16'h8204 && io_req.wdata == 8'h5A;
        end
    end

    always_ff @(posedge clk_sys) begin
        wd_q <= io_req.wdata;
        bs_q <= boot_select_inputs;
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    chk_hw_reset_cmd: assert property (hw_reset_pulse == a5_q)
        else $error("bad reset pulse");
    chk_power_cmd: assert property (power_cycle_pulse == x5a_q)
        else $error("bad power pulse");
    chk_flag_falls: assert property ($fell(timeout_occurred_n) |->
        wdt_reset_pulse || wdt_nmi_pulse)
        else $error("flag fell alone");
    chk_flag_clears: assert property ($rose(timeout_occurred_n) |->
        hw_reset_pulse || power_cycle_pulse)
        else $error("flag rose alone");
    chk_nmi_route: assert property (wdt_nmi_pulse |->
        $past(timeout_action_select))
        else $error("nmi misrouted");
    chk_reset_route: assert property (wdt_reset_pulse |->
        !$past(timeout_action_select))
        else $error("reset misrouted");
    chk_setup_outputs: assert property (wr_ok && io_req.addr == 16'h8205 |=>
        {ready_led, aux_led, usb_pair_power_c, usb_pair_power_b,
         usb_pair_power_a} == {wd_q[7], wd_q[5], wd_q[2:0]})
        else $error("setup pins wrong");
    chk_sensor_drive: assert property (wr_ok && io_req.addr == 16'h820B |=>
        sensor_clk_pin.oe == !wd_q[7] && sensor_data_pin.oe == !wd_q[6])
        else $error("line enable wrong");
    chk_sensor_low: assert property (!sensor_clk_pin.o && !sensor_data_pin.o)
        else $error("line driven high");
    chk_revision_read: assert property (rd_ok && io_req.addr == 16'h8206 |=>
        io_rdata == REVISION_CODE)
        else $error("revision read wrong");
    chk_boot_read: assert property (rd_ok && io_req.addr == 16'h820A |=>
        io_rdata == {6'h00, bs_q})
        else $error("boot mode read wrong");

    cover property (hw_reset_pulse);
    cover property (power_cycle_pulse);
    cover property (wdt_reset_pulse);
    cover property (wdt_nmi_pulse);
endmodule

bind board_system_register_bank board_regs_chk #(
    .REVISION_CODE(REVISION_CODE)
) chk_inst (.*);

`default_nettype wire

// file: bench/test_board_system_register_bank.sv
// self-checking testbench for the board system register bank
`timescale 1ns/1ps
`default_nettype none

module test_board_system_register_bank;
    import board_regs_pkg::*;

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    localparam logic [7:0] OPT = 8'h3C; // arbitrary value
    localparam logic [7:0] REV = 8'h01; // arbitrary value
    logic clk_sys, resetn, ce, kick, act, clk_ext;
    logic [3:0] sw;
    logic [1:0] boot;
    logic [7:0] io_rdata;
    io_req_s    io_req;
    oc_pin_s    clk_pin, data_pin;
    logic flag_n, hw_p, pwr_p, wrst_p, nmi_p, rdy, aux, ua, ub, uc;
    int fail_count = 0;
    int num_checks = 0;
    // pull-ups; clk_ext is another device pulling low
    wire logic clk_in  = !(clk_pin.oe | clk_ext);
    wire logic data_in = !data_pin.oe;
    // bit 24 write, 23..8 address, 7..0 data or expected read
    logic [24:0] rows [25] = '{
        25'h08203_80, 25'h08205_07, 25'h08206_01, 25'h08204_3C, 25'h0820A_02,
        25'h0820B_FF, 25'h08207_FF, 25'h18203_F3, 25'h08203_83, 25'h18203_00,
        25'h08203_00, 25'h18206_00, 25'h08206_01, 25'h18205_BA, 25'h08205_A2,
        25'h18205_00, 25'h08205_00, 25'h1820B_7F, 25'h0820B_5F, 25'h1820B_BF,
        25'h0820B_AF, 25'h1820B_FF, 25'h0820B_FF, 25'h18204_12, 25'h08204_3C};

    // short tick keeps long periods cheap
    board_system_register_bank #(
        .TICK_CYCLES(4), .OPTION_CODE(OPT), .REVISION_CODE(REV)
    ) board_system_register_bank_inst (
        .clk_sys, .resetn, .ce, .io_req, .io_rdata, .watchdog_kick(kick),
        .timeout_action_select(act), .config_switch(sw),
        .timeout_occurred_n(flag_n), .hw_reset_pulse(hw_p),
        .power_cycle_pulse(pwr_p), .wdt_reset_pulse(wrst_p),
        .wdt_nmi_pulse(nmi_p), .ready_led(rdy), .aux_led(aux),
        .usb_pair_power_a(ua), .usb_pair_power_b(ub), .usb_pair_power_c(uc),
        .boot_select_inputs(boot), .sensor_clk_in(clk_in),
        .sensor_data_in(data_in), .sensor_clk_pin(clk_pin),
        .sensor_data_pin(data_pin));

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        io_req = {a, w, !w, d};
        @(negedge clk_sys);
        {io_req.wr, io_req.rd} = 2'b00;
    endtask

    task automatic kick_it;
        @(negedge clk_sys);
        kick = !kick;
    endtask

    task automatic wdt_wait(input int lo, input int hi);
        int n = 0;
        while (!(wrst_p | nmi_p) && n < 3000) begin
            @(negedge clk_sys);
            n++;
        end
        chk({7'h00, n >= lo && n <= hi}, 8'h01);
        chk({7'h00, flag_n}, 8'h00);
    endtask

    task automatic quiet(input int n);
        logic seen = 1'b0;
        repeat (n) begin
            @(negedge clk_sys);
            seen = seen | wrst_p | nmi_p;
        end
        chk({7'h00, seen}, 8'h00);
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = !clk_sys;
    end

    initial begin
        #50000;
        fail_count++;
        give_verdict();
    end

    initial begin
        {resetn, kick, act, clk_ext} = 4'h0;
        ce = 1'b1;
        sw = 4'h1;
        boot = 2'b10;
        io_req = '0;
        repeat (6) @(negedge clk_sys);
        chk({flag_n, rdy, aux, uc, ub, ua, clk_pin.oe, data_pin.oe}, 8'h9C);
        chk(io_rdata, 8'hFF);
        resetn = 1'b1;
        foreach (rows[i]) begin
            acc(rows[i][24], rows[i][23:8], rows[i][7:0]);
            if (!rows[i][24]) chk(io_rdata, rows[i][7:0]);
        end
        // ce low ignores access
        ce = 1'b0;
        acc(1'b1, 16'h8205, 8'hFF);
        ce = 1'b1;
        acc(1'b0, 16'h8205, 8'h00);
        chk(io_rdata, 8'h00);
        // pin level, not latch, is read back
        clk_ext = 1'b1;
        acc(1'b0, 16'h820B, 8'h00);
        chk(io_rdata, 8'h5F);
        clk_ext = 1'b0;
        // locked watchdog, code 0 with odd switch
        acc(1'b1, 16'h8203, 8'h80);
        acc(1'b1, 16'h8205, 8'h40);
        wdt_wait(4, 7);
        acc(1'b1, 16'h8205, 8'h00);
        acc(1'b0, 16'h8205, 8'h00);
        chk(io_rdata, 8'h40);
        quiet(30);
        kick_it();
        wdt_wait(4, 7);
        acc(1'b1, 16'h8204, 8'hA5);
        chk({6'h00, hw_p, flag_n}, 8'h03);
        sw = 4'h2;
        kick_it();
        wdt_wait(40, 43);
        acc(1'b1, 16'h8203, 8'h81);
        sw = 4'h1;
        kick_it();
        wdt_wait(160, 163);
        act = 1'b1;
        kick_it();
        wdt_wait(160, 163);
        chk({7'h00, nmi_p}, 8'h01);
        acc(1'b1, 16'h8204, 8'h5A);
        chk({6'h00, pwr_p, flag_n}, 8'h03);
        // unlocked: can switch off
        acc(1'b1, 16'h8203, 8'h00);
        acc(1'b1, 16'h8205, 8'h07);
        acc(1'b0, 16'h8205, 8'h00);
        chk(io_rdata, 8'h07);
        kick_it();
        quiet(200);
        give_verdict();
    end
endmodule

`default_nettype wire
